// ==== design/brwa_pkg.sv ====
// package: register map, fields and constants of the boot rom width adapter
package brwa_pkg;
	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0]  ROM_BANK_CONTROL_OFS      = 8'h80;
	localparam logic [7:0]  CLOCK_DIVIDER_CONTROL_OFS = 8'h84;
	localparam logic [7:0]  FETCH_STATUS_OFS          = 8'h88;
	localparam logic [31:0] CTRL_BASE_ADDR            = 32'h03200000;
	// ----------------------------------------
	// fields and reset values
	// ----------------------------------------
	localparam int          ROM_WIDTH16_BIT   = 6;
	localparam logic [7:0]  ROM_BANK_CTRL_RST = 8'h40;
	localparam int          DIV_CPU_BIT       = 0;
	localparam int          DIV_MEM_BIT       = 1;
	localparam int          DIV_IO_BIT        = 2;
	localparam logic [2:0]  CLK_DIV_RST       = 3'h7;
	localparam logic [31:0] FETCH_RESET_ADDR  = 32'h00000000;
	localparam logic [31:0] ROM_WORD_STEP     = 32'h00000004;
endpackage : brwa_pkg

// ==== design/brwa_rom_port.sv ====
// rom read port: one rom location read per request with a programmable wait
`timescale 1ns/100ps
module brwa_rom_port
	import brwa_pkg::*;
#(
	parameter int WAIT_W = 4
) (
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst,
	input  wire logic              i_req,
	input  wire logic [31:0]       i_addr,
	input  wire logic [WAIT_W-1:0] i_wait,
	output logic                   o_done,
	output logic [31:0]            o_data,
	output logic [31:0]            o_rom_addr,
	output logic                   o_rom_rd,
	input  wire logic [31:0]       i_rom_data
);
	typedef struct packed {
		logic              busy;
		logic [WAIT_W-1:0] cnt;
		logic              done;
		logic [31:0]       data;
		logic [31:0]       addr;
	} brwa_port_t;
	brwa_port_t s_reg, s_next;

	always_comb begin
		s_next      = s_reg;
		s_next.done = 1'b0;
		if (!s_reg.busy && i_req) begin
			s_next.busy = 1'b1;
			s_next.addr = i_addr;
			s_next.cnt  = i_wait;
		end else if (s_reg.busy) begin
			if (s_reg.cnt == '0) begin
				s_next.busy = 1'b0;
				s_next.done = 1'b1;
				s_next.data = i_rom_data;
			end else begin
				s_next.cnt = s_reg.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_done     = s_reg.done;
	assign o_data     = s_reg.data;
	assign o_rom_addr = s_reg.addr;
	assign o_rom_rd   = s_reg.busy;
endmodule : brwa_rom_port

// ==== design/brwa_top.sv ====
// boot rom width adapter: wishbone registers and fetch assembly
`timescale 1ns/100ps
module brwa_top
	import brwa_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic             o_wb_ack,
	output logic [31:0]      o_wb_dat,
	input  wire logic        i_fetch_req,
	input  wire logic [31:0] i_fetch_addr,
	output logic             o_fetch_ack,
	output logic [31:0]      o_fetch_data,
	output logic [31:0]      o_fetch_next,
	output logic [31:0]      o_rom_addr,
	output logic             o_rom_rd,
	input  wire logic [31:0] i_rom_data,
	output logic [2:0]       o_clk_div2
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_DONE} brwa_state_t;
	typedef struct packed {
		brwa_state_t state;
		logic        mode16;
		logic [31:0] addr;
		logic [15:0] low_half;
		logic        fetch_ack;
		logic [31:0] fetch_data;
		logic [31:0] fetch_next;
		logic [7:0]  rom_ctrl;
		logic [2:0]  clk_div;
		logic        wb_ack;
		logic [31:0] wb_dat;
	} brwa_top_t;
	brwa_top_t s_reg, s_next;

	logic        port_req;
	logic [31:0] port_addr;
	logic        port_done;
	logic [31:0] port_data;
	logic        wb_hit;

	// wait states: low nibble of control, inverted so zero means slowest
	brwa_rom_port #(.WAIT_W(4)) u_port (
		.i_ref_clk  (i_ref_clk),
		.i_rst      (i_rst),
		.i_req      (port_req),
		.i_addr     (port_addr),
		.i_wait     (~s_reg.rom_ctrl[3:0]),
		.o_done     (port_done),
		.o_data     (port_data),
		.o_rom_addr (o_rom_addr),
		.o_rom_rd   (o_rom_rd),
		.i_rom_data (i_rom_data)
	);

	assign wb_hit = i_wb_cyc && i_wb_stb && !s_reg.wb_ack;

	always_comb begin
		s_next           = s_reg;
		s_next.fetch_ack = 1'b0;
		s_next.wb_ack    = 1'b0;
		port_req         = 1'b0;
		port_addr        = s_reg.addr;
		// ----------------------------------------
		// register slave
		// ----------------------------------------
		if (wb_hit) begin
			s_next.wb_ack = 1'b1;
			s_next.wb_dat = '0;
			unique case (i_wb_adr)
				ROM_BANK_CONTROL_OFS: begin
					if (i_wb_we && i_wb_sel[0]) begin
						s_next.rom_ctrl = i_wb_dat[7:0];
					end
					s_next.wb_dat = {24'h000000, s_reg.rom_ctrl};
				end
				CLOCK_DIVIDER_CONTROL_OFS: begin
					if (i_wb_we && i_wb_sel[0]) begin
						s_next.clk_div = i_wb_dat[2:0];
					end
					s_next.wb_dat = {29'h00000000, s_reg.clk_div};
				end
				FETCH_STATUS_OFS: begin
					s_next.wb_dat = {29'h00000000, s_reg.mode16, s_reg.state};
				end
				default: begin
					s_next.wb_dat = 32'h00000000;
				end
			endcase
		end
		// ----------------------------------------
		// fetch assembly
		// ----------------------------------------
		unique case (s_reg.state)
			ST_IDLE: begin
				if (i_fetch_req) begin
					// width latched per fetch so a write mid-fetch cannot split it
					s_next.mode16 = s_reg.rom_ctrl[ROM_WIDTH16_BIT];
					s_next.addr   = i_fetch_addr;
					s_next.state  = ST_LOW;
					port_req      = 1'b1;
					port_addr     = i_fetch_addr;
				end
			end
			ST_LOW: begin
				if (port_done) begin
					if (s_reg.mode16) begin
						s_next.low_half = port_data[15:0];
						s_next.state    = ST_HIGH;
						port_req        = 1'b1;
						port_addr       = s_reg.addr + ROM_WORD_STEP;
					end else begin
						s_next.fetch_data = port_data;
						s_next.state      = ST_DONE;
					end
				end
			end
			ST_HIGH: begin
				if (port_done) begin
					// both halves in hand before the fetch is released
					s_next.fetch_data = {port_data[15:0], s_reg.low_half};
					s_next.state      = ST_DONE;
				end
			end
			ST_DONE: begin
				s_next.fetch_ack  = 1'b1;
				s_next.fetch_next = s_reg.addr + (s_reg.mode16 ? 32'h00000008 : ROM_WORD_STEP);
				s_next.state      = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			s_reg            <= '0;
			s_reg.state      <= ST_IDLE;
			s_reg.rom_ctrl   <= ROM_BANK_CTRL_RST;
			s_reg.mode16     <= 1'b1;
			s_reg.clk_div    <= CLK_DIV_RST;
			s_reg.fetch_next <= FETCH_RESET_ADDR;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_wb_ack     = s_reg.wb_ack;
	assign o_wb_dat     = s_reg.wb_dat;
	assign o_fetch_ack  = s_reg.fetch_ack;
	assign o_fetch_data = s_reg.fetch_data;
	assign o_fetch_next = s_reg.fetch_next;
	assign o_clk_div2   = s_reg.clk_div;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_reset_width16: assert property (@(posedge i_ref_clk)
		$fell(i_rst) |-> s_reg.rom_ctrl == ROM_BANK_CTRL_RST)
		else $error("rom control not 16-bit after reset");
	a_reset_div2: assert property (@(posedge i_ref_clk)
		$fell(i_rst) |-> o_clk_div2 == CLK_DIV_RST)
		else $error("divider not divide-by-2 after reset");
	a_reset_vector: assert property (@(posedge i_ref_clk)
		$fell(i_rst) |-> o_fetch_next == FETCH_RESET_ADDR)
		else $error("fetch does not start at zero");
	a_reset_idle: assert property (@(posedge i_ref_clk)
		$fell(i_rst) |-> (s_reg.state == ST_IDLE && !o_rom_rd && !o_fetch_ack))
		else $error("fetch path busy right after reset");
	a_high_step: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_reg.state == ST_LOW && port_done && s_reg.mode16)
		|-> port_addr == s_reg.addr + ROM_WORD_STEP)
		else $error("upper half not read from location plus four");
	a_low_rom_addr: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_reg.state == ST_IDLE && i_fetch_req)
		|=> (o_rom_rd && o_rom_addr == $past(i_fetch_addr)))
		else $error("first read not at the fetch address");
	a_high_rom_addr: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_reg.state == ST_HIGH && o_rom_rd)
		|-> o_rom_addr == s_reg.addr + ROM_WORD_STEP)
		else $error("upper half read on the wrong rom location");
	a_merge_halves: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_reg.state == ST_HIGH && port_done)
		|=> o_fetch_data == {$past(port_data[15:0]), $past(s_reg.low_half)})
		else $error("fetch word not assembled from low halves");
	a_ctrl_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(wb_hit && i_wb_we && i_wb_sel[0] && i_wb_adr == ROM_BANK_CONTROL_OFS)
		|=> s_reg.rom_ctrl == $past(i_wb_dat[7:0]))
		else $error("control byte write lost");
	a_wb_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_wb_ack |=> !o_wb_ack)
		else $error("bus acknowledge longer than one cycle");
	a_div_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(wb_hit && i_wb_we && i_wb_sel[0] && i_wb_adr == CLOCK_DIVIDER_CONTROL_OFS)
		|=> s_reg.clk_div == $past(i_wb_dat[2:0]))
		else $error("divider byte write lost");
	a_zero_wide: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_reg.state == ST_IDLE && i_fetch_req && s_reg.rom_ctrl == 8'h00)
		|=> !s_reg.mode16)
		else $error("zero write did not select 32-bit");
	a_zero_slow: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_reg.state == ST_IDLE && i_fetch_req && s_reg.rom_ctrl[3:0] == 4'h0)
		|-> ##16 !port_done ##1 port_done)
		else $error("zero timing field not the slowest access");
	a_mode_stable: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_reg.state != ST_IDLE && s_reg.state != ST_DONE) |=> $stable(s_reg.mode16))
		else $error("width changed during a fetch");
	a_hold_fetch: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_reg.state == ST_HIGH || (s_reg.state == ST_LOW && s_reg.mode16)) |-> !o_fetch_ack)
		else $error("fetch released before both halves");
	a_fetch_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_fetch_ack |=> !o_fetch_ack)
		else $error("fetch acknowledge longer than one cycle");
endmodule : brwa_top

// ==== bench/brwa_rom_model.sv ====
// parallel rom bank partner: answers reads, scrambles the bus while idle
`timescale 1ns/100ps
module brwa_rom_model (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rd,
	input  wire logic [31:0] i_addr,
	output logic [31:0]      o_data
);
	logic [31:0] last_reg;
	// halves differ so a lane slip shows; idle bus toggles so stale data never matches
	assign o_data = i_rd ? {i_addr[15:0] ^ 16'hA5C3, i_addr[15:0] + 16'h1357} : ~last_reg;
	always_ff @(posedge i_ref_clk) begin
		last_reg <= o_data;
	end
endmodule : brwa_rom_model

// ==== bench/boot_rom_width_adapter_bench.sv ====
// self-checking bench of the boot rom width adapter
`timescale 1ns/100ps
module boot_rom_width_adapter_bench
	import brwa_pkg::*;
;
	logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0, faddr = 32'h0;
	logic [31:0] rdat, rom_d, rom_a, fdata, fnext;
	logic        ack, fack, rom_rd;
	logic [2:0]  div;
	logic [7:0]  ctrl_m = 8'h40;
	int          error_cnt = 0, n_tests = 0, cyc_cnt = 0;

	brwa_top u_dut (
		.i_ref_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat),
		.i_fetch_req(req), .i_fetch_addr(faddr), .o_fetch_ack(fack), .o_fetch_data(fdata),
		.o_fetch_next(fnext), .o_rom_addr(rom_a), .o_rom_rd(rom_rd), .i_rom_data(rom_d),
		.o_clk_div2(div)
	);
	brwa_rom_model u_rom (.i_ref_clk(clk), .i_rd(rom_rd), .i_addr(rom_a), .o_data(rom_d));

	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 5000) begin
			error_cnt++;
			summarize();
		end
	end
	// ------
	// tasks
	// ------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [31:0] rom_word(input logic [31:0] a);
		return {a[15:0] ^ 16'hA5C3, a[15:0] + 16'h1357};
	endfunction : rom_word
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s, output logic [31:0] r);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		r = rdat;
		if (w && s[0] && a == 8'h80) ctrl_m = d[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic fetch(input logic [31:0] a);
		int n;
		int w;
		logic m16;
		logic [31:0] lo;
		logic [31:0] hi;
		m16 = ctrl_m[6];
		w = 15 - ctrl_m[3:0];
		lo = rom_word(a);
		hi = rom_word(a + 32'h4);
		faddr <= a;
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		n = 1;
		while (fack !== 1'b1) begin
			@(posedge clk);
			n++;
		end
		chk(32'(n), m16 ? 32'(2 * w + 7) : 32'(w + 5));
		chk(fdata, m16 ? {hi[15:0], lo[15:0]} : lo);
		chk(fnext, a + (m16 ? 32'h8 : 32'h4));
	endtask : fetch
	task automatic summarize();
		if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	// ------
	// sequence
	// ------
	initial begin
		logic [31:0] r;
		logic [31:0] d;
		void'($urandom(95));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		chk({29'h0, div}, 32'h7);
		chk(fnext, 32'h0);
		wb(1'b0, 8'h80, 32'h0, 4'hF, r);
		chk(r, 32'h40);
		wb(1'b0, 8'h84, 32'h0, 4'hF, r);
		chk(r, 32'h7);
		wb(1'b0, 8'hFC, 32'h0, 4'hF, r);
		chk(r, 32'h0);
		fetch(32'h0);
		repeat (3) fetch($urandom & 32'h00FFFFFC);
		// byte lane zero off: store must be ignored
		wb(1'b1, 8'h80, 32'hFF, 4'hE, r);
		wb(1'b0, 8'h80, 32'h0, 4'hF, r);
		chk(r, {24'h0, ctrl_m});
		wb(1'b1, 8'h80, 32'h4F, 4'h1, r);
		fork
			fetch($urandom & 32'h00FFFFFC);
			begin
				// lands mid-fetch, on the same edge as the upper-half read takes its wait count
				repeat (2) @(posedge clk);
				wb(1'b1, 8'h80, 32'h0, 4'h1, r);
			end
		join
		wb(1'b0, 8'h80, 32'h0, 4'hF, r);
		chk(r, 32'h0);
		fetch($urandom & 32'h00FFFFFC);
		d = $urandom & 32'h7;
		wb(1'b1, 8'h84, d, 4'h1, r);
		chk({29'h0, div}, d);
		wb(1'b0, 8'h84, 32'h0, 4'hF, r);
		chk(r, d);
		// second reset in mid-run: defaults must come back
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		ctrl_m = 8'h40;
		wb(1'b0, 8'h80, 32'h0, 4'hF, r);
		chk(r, 32'h40);
		chk({29'h0, div}, 32'h7);
		chk(fnext, 32'h0);
		fetch(32'h0);
		summarize();
	end
endmodule : boot_rom_width_adapter_bench
